// ===== rtl/mtio_expansion.sv
// Motion task I/O expansion: input sync, start/jog events, output refresh
`timescale 1ns/10ps
`include "mtio_map.svh"
module mtio_expansion (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // Isolated connector inputs (asynchronous)
  input  wire mtio_pkg::mtio_in_type pinIn,
  // Basic-unit configuration and inputs
  input  wire logic                  baseRefSel,
  input  wire logic                  baseRefIn,
  input  wire logic                  baseStartNext,
  // Motion engine status
  input  wire mtio_pkg::mtio_stat_type engStat,
  input  wire logic                  targetReached,
  input  wire logic                  followWarnSet,
  input  wire logic                  respWarnSet,
  input  wire logic                  outFault,
  input  wire logic                  auxSupply,
  // Commands to the motion engine
  output logic                       startTaskPulse,
  output logic [7:0]                 startTaskNum,
  output logic                       startNextPulse,
  output logic                       restartPulse,
  output logic                       jogActive,
  output logic                       refSwitchOut,
  output logic                       followErrWarning,
  output logic                       responseMonitorWarning,
  // Connector outputs and LEDs
  output logic [7:0]                 digOut,
  output logic                       faultLed,
  output logic                       supplyLed
);

  // ==========================================
  // Two-stage synchronisers on every isolated input
  mtio_pkg::mtio_in_type syncA_ff, syncB_ff, prev_ff;
  logic baseA_ff, baseB_ff, baseNextPrev_ff;
  logic [2:0] aux1_ff, aux2_ff;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      syncA_ff <= '0;
      syncB_ff <= '0;
    end else begin
      syncA_ff <= pinIn;
      syncB_ff <= syncA_ff;
    end
  end

  // Basic-unit start-next, fault and supply pins cross into the clock domain too; baseRefSel and baseRefIn do not
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aux1_ff <= 3'h0;
      aux2_ff <= 3'h0;
    end else begin
      aux1_ff <= {baseStartNext, outFault, auxSupply};
      aux2_ff <= aux1_ff;
    end
  end

  // Previous values for edge detection, taken after the second stage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_ff         <= '0;
      baseNextPrev_ff <= 1'b0;
    end else begin
      prev_ff         <= syncB_ff;
      baseNextPrev_ff <= aux2_ff[2];
    end
  end

  // ==========================================
  // Edge decoding
  // Rising edge of a synchronised level against its value one cycle ago
  function automatic logic riseOf(input logic cur, input logic old);
    return cur & ~old;
  endfunction : riseOf

  wire startSelRise  = riseOf(syncB_ff.startSel, prev_ff.startSel);
  wire nextCardRise  = riseOf(syncB_ff.startNext, prev_ff.startNext);
  wire nextBaseRise  = riseOf(aux2_ff[2], baseNextPrev_ff);
  wire restartRise   = riseOf(syncB_ff.restart, prev_ff.restart);
  wire jogRise       = riseOf(syncB_ff.jog, prev_ff.jog);
  wire jogFall       = riseOf(prev_ff.jog, syncB_ff.jog);
  wire errClearRise  = riseOf(syncB_ff.errClear, prev_ff.errClear);
  // Next task waits for target; request is held until then
  wire nextReq       = nextCardRise | nextBaseRise;
  logic nextPend_ff;
  wire nextFire      = (nextReq | nextPend_ff) & targetReached;

  // ==========================================
  // Start commands, task number latched with the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      startTaskPulse <= 1'b0;
      startTaskNum   <= `MTIO_TASK_RST;
      startNextPulse <= 1'b0;
      restartPulse   <= 1'b0;
      nextPend_ff    <= 1'b0;
    end else begin
      startTaskPulse <= startSelRise;
      if (startSelRise)
        startTaskNum <= syncB_ff.taskSel;
      startNextPulse <= nextFire;
      restartPulse   <= restartRise;
      nextPend_ff    <= (nextReq | nextPend_ff) & ~targetReached;
    end
  end

  // ==========================================
  // Jog state machine
  mtio_pkg::mtio_jog_type jogSt_ff, nxt_jogSt;
  always_comb begin
    case (jogSt_ff)
      mtio_pkg::JOG_IDLE: nxt_jogSt = jogRise ? mtio_pkg::JOG_RUN
                                              : mtio_pkg::JOG_IDLE;
      mtio_pkg::JOG_RUN:  nxt_jogSt = jogFall ? mtio_pkg::JOG_IDLE
                                              : mtio_pkg::JOG_RUN;
      default:            nxt_jogSt = mtio_pkg::JOG_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) jogSt_ff <= mtio_pkg::JOG_IDLE;
    else     jogSt_ff <= nxt_jogSt;
  end
  assign jogActive = (jogSt_ff == mtio_pkg::JOG_RUN);

  // ==========================================
  // Reference switch select and warnings; a new warning beats a clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      refSwitchOut           <= 1'b0;
      followErrWarning       <= 1'b0;
      responseMonitorWarning <= 1'b0;
    end else begin
      refSwitchOut <= baseRefSel ? baseRefIn : syncB_ff.refSwitch;
      followErrWarning <= followWarnSet |
                          (followErrWarning & ~errClearRise);
      responseMonitorWarning <= respWarnSet |
                          (responseMonitorWarning & ~errClearRise);
    end
  end

  // ==========================================
  // Output refresh: status sampled every 2.5 ms, so change shows in time
  logic [17:0] refreshCnt_ff;
  wire refreshTick = (refreshCnt_ff == `MTIO_REFRESH_CYC - 18'h00001);
  wire [7:0] outNext = {engStat.posReg, engStat.followOk,
                        engStat.nextInPos, engStat.inWindow};
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      refreshCnt_ff <= 18'h00000;
      digOut        <= 8'h00;
    end else begin
      refreshCnt_ff <= refreshTick ? 18'h00000 : refreshCnt_ff + 18'h00001;
      if (refreshTick)
        digOut <= outNext;
    end
  end

  // Assertion helper: cycles that digOut lags a steady engine status;
  // a fresh status change restarts the count, as it supersedes the old one
  logic [7:0]  statPrev_ff;
  logic [17:0] staleCnt_ff;
  wire         statSteady = (outNext == statPrev_ff);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      statPrev_ff <= 8'h00;
      staleCnt_ff <= 18'h00000;
    end else begin
      statPrev_ff <= outNext;
      if (digOut == outNext || !statSteady)
        staleCnt_ff <= 18'h00000;
      else
        staleCnt_ff <= staleCnt_ff + 18'h00001;
    end
  end

  // LEDs follow synchronised fault and supply levels
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      faultLed  <= 1'b0;
      supplyLed <= 1'b0;
    end else begin
      faultLed  <= aux2_ff[1];
      supplyLed <= aux2_ff[0];
    end
  end

  // ==========================================
  // Assertions
  a_start_task_num: assert property (@(posedge ref_clk) disable iff (rst)
    startSelRise |=> startTaskPulse && startTaskNum == $past(syncB_ff.taskSel))
    else $error("task number not latched");
  a_task_bits: assert property (@(posedge ref_clk) disable iff (rst)
    startTaskPulse |-> startTaskNum == $past(syncB_ff.taskSel, 1))
    else $error("task bit order wrong");
  a_next_waits: assert property (@(posedge ref_clk) disable iff (rst)
    startNextPulse |-> $past(targetReached))
    else $error("next task before target");
  a_base_next: assert property (@(posedge ref_clk) disable iff (rst)
    nextBaseRise && targetReached |=> startNextPulse)
    else $error("basic-unit next ignored");
  a_jog_start: assert property (@(posedge ref_clk) disable iff (rst)
    jogRise |=> jogActive)
    else $error("jog not started");
  a_jog_cancel: assert property (@(posedge ref_clk) disable iff (rst)
    jogFall |=> !jogActive)
    else $error("jog not cancelled");
  a_ref_select: assert property (@(posedge ref_clk) disable iff (rst)
    baseRefSel |=> refSwitchOut == $past(baseRefIn))
    else $error("card reference not ignored");
  a_warn_clear: assert property (@(posedge ref_clk) disable iff (rst)
    errClearRise && !followWarnSet |=> !followErrWarning)
    else $error("warning not cleared");
  a_out_refresh: assert property (@(posedge ref_clk) disable iff (rst)
    refreshTick |=> digOut[0] == $past(engStat.inWindow) &&
                    digOut[2] == $past(engStat.followOk))
    else $error("outputs not refreshed");
  a_refresh_bound: assert property (@(posedge ref_clk) disable iff (rst)
    staleCnt_ff < `MTIO_RESP_CYCLES)
    else $error("outputs lag status too long");
  a_fault_led: assert property (@(posedge ref_clk) disable iff (rst)
    aux2_ff[1] |=> faultLed)
    else $error("fault led missing");
endmodule : mtio_expansion

// ===== rtl/mtio_map.svh
// Constants of the motion task I/O expansion block
// Behaviour
// - Fourteen fixed inputs, eight fixed outputs
// - Task number binary, bit0 LSB to bit7
// - Card reference ignored when basic input used
// - Error clear drops following/response warnings
// - Start next task only after target reached
// - Basic-unit input also starts next task
// - Jog rises starts, falling edge cancels
// - Outputs follow status within 10 ms
// - Fault LED on overload; supply LED
// - In-position output high inside window
// - Following-error output low outside window
// - Start-task starts selected task number
`ifndef MTIO_MAP_SVH
`define MTIO_MAP_SVH
// ==========================================
// Timing
`define MTIO_CLK_NS        50
`define MTIO_RESP_MAX_MS   10
`define MTIO_RESP_CYCLES   ((`MTIO_RESP_MAX_MS * 1000000) / `MTIO_CLK_NS)
// Output refresh period, well inside the response limit
`define MTIO_REFRESH_CYC   18'h0c350
// ==========================================
// Field widths and reset values
`define MTIO_TASK_W        8
`define MTIO_TASK_RST      8'h00
`endif

// ===== rtl/mtio_pkg.sv
// Types of the motion task I/O expansion block
package mtio_pkg;
  // Synchronised isolated inputs from the connector
  typedef struct packed {
    logic [7:0] taskSel;
    logic       refSwitch;
    logic       errClear;
    logic       startNext;
    logic       jog;
    logic       startSel;
    logic       restart;
  } mtio_in_type;

  // Status from the motion engine
  typedef struct packed {
    logic inWindow;
    logic followOk;
    logic nextInPos;
    logic [4:0] posReg;
  } mtio_stat_type;

  typedef enum logic [1:0] {
    JOG_IDLE = 2'b00,
    JOG_RUN  = 2'b01
  } mtio_jog_type;
endpackage : mtio_pkg

// ===== verif/mtio_expansion_test.sv
// Self-checking bench of the motion task I/O expansion block
`timescale 1ns/10ps
module mtio_expansion_test;
  logic ref_clk = 0, rst = 1, baseRefSel = 0, baseRefIn = 0;
  logic baseStartNext = 0, targetReached = 0, followWarnSet = 0;
  logic respWarnSet = 0, outFault = 0, auxSupply = 0;
  mtio_pkg::mtio_stat_type engStat = '0;
  mtio_pkg::mtio_in_type   pinIn;
  logic sTask, sNext, sRst, jogActive, refSwitchOut, fw, rw, fLed, sLed;
  logic [7:0] taskNum, digOut, nTask = 0, nNext = 0, nRst = 0, lastNum;
  int err_total = 0, check_count = 0, seed = 70;
  logic [7:0] num;
  logic [31:0] rnd;
  mtio_plc_model i_mtio_plc_model (.ref_clk(ref_clk), .pinIn(pinIn));
  mtio_expansion i_mtio_expansion (.ref_clk(ref_clk), .rst(rst),
    .pinIn(pinIn), .baseRefSel(baseRefSel), .baseRefIn(baseRefIn),
    .baseStartNext(baseStartNext), .engStat(engStat),
    .targetReached(targetReached), .followWarnSet(followWarnSet),
    .respWarnSet(respWarnSet), .outFault(outFault), .auxSupply(auxSupply),
    .startTaskPulse(sTask), .startTaskNum(taskNum), .startNextPulse(sNext),
    .restartPulse(sRst), .jogActive(jogActive), .refSwitchOut(refSwitchOut),
    .followErrWarning(fw), .responseMonitorWarning(rw), .digOut(digOut),
    .faultLed(fLed), .supplyLed(sLed));
  // ==========================================
  // Clock, pulse counters sampled where settled
  initial forever #25 ref_clk = ~ref_clk;
  always @(negedge ref_clk) begin
    if (sTask === 1'b1) begin
      nTask++;
      lastNum = taskNum;
    end
    if (sNext === 1'b1) nNext++;
    if (sRst === 1'b1) nRst++;
  end
  // Expected connector outputs from engine status
  function automatic logic [7:0] expOut(mtio_pkg::mtio_stat_type s);
    return {s.posReg, s.followOk, s.nextInPos, s.inWindow};
  endfunction : expOut
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic waitN(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : waitN
  task automatic results;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  // Watchdog sized for one refresh period plus the event scenarios
  initial begin
    #(70000 * 50);
    err_total++;
    results();
  end
  // ==========================================
  // Main sequence
  initial begin
    waitN(4);
    rst = 0;
    waitN(1);
    chk("warnRst", {fw, rw, jogActive, sTask, sNext, sRst}, 8'h00);
    chk("ledRst", {refSwitchOut, fLed, sLed}, 8'h00);
    chk("numRst", taskNum, 8'h00);
    chk("outRst", digOut, 8'h00);
    for (int i = 0; i < 5; i++) begin
      rnd = $random(seed);
      num = (i == 0) ? 8'hae : (i == 1) ? 8'hff : rnd[7:0];
      i_mtio_plc_model.pulseLine(1, num);
      chk("nTask", nTask, 8'(i + 1));
      chk("taskNum", lastNum, num);
    end
    i_mtio_plc_model.pulseLine(0, 8'h00);
    chk("nRst", nRst, 8'h01);
    i_mtio_plc_model.pulseLine(3, 8'h00);
    chk("nextHeld", nNext, 8'h00);
    targetReached = 1;
    waitN(3);
    chk("nextGo", nNext, 8'h01);
    baseStartNext = 1;
    waitN(4);
    baseStartNext = 0;
    waitN(4);
    chk("baseNext", nNext, 8'h02);
    i_mtio_plc_model.setLine(2, 1'b1);
    waitN(4);
    chk("jogOn", jogActive, 8'h01);
    i_mtio_plc_model.setLine(2, 1'b0);
    waitN(4);
    chk("jogOff", jogActive, 8'h00);
    followWarnSet = 1;
    respWarnSet = 1;
    waitN(1);
    {followWarnSet, respWarnSet} = 2'b00;
    waitN(2);
    chk("warnSet", {fw, rw}, 8'h03);
    i_mtio_plc_model.pulseLine(4, 8'h00);
    chk("warnClr", {fw, rw}, 8'h00);
    i_mtio_plc_model.setLine(5, 1'b1);
    waitN(4);
    chk("refCard", refSwitchOut, 8'h01);
    baseRefSel = 1;
    waitN(3);
    chk("refBase", refSwitchOut, 8'h00);
    baseRefIn = 1;
    waitN(2);
    chk("refBaseHi", refSwitchOut, 8'h01);
    rnd = $random(seed);
    engStat = rnd[7:0];
    {outFault, auxSupply} = 2'b11;
    waitN(50005);
    chk("digOut", digOut, expOut(engStat));
    chk("leds", {fLed, sLed}, 8'h03);
    results();
  end
endmodule : mtio_expansion_test

// ===== verif/mtio_plc_model.sv
// Controller model driving the isolated connector inputs
`timescale 1ns/10ps
module mtio_plc_model (
  // Clock
  input  wire logic             ref_clk,
  // Connector lines
  output mtio_pkg::mtio_in_type pinIn
);
  // ==========================================
  // Line drive, always just after the falling edge
  initial pinIn = '0;
  // Task number settles before the strobe, low gaps keep rises apart
  task automatic pulseLine(input int idx, input logic [7:0] num);
    @(negedge ref_clk);
    pinIn.taskSel = num;
    repeat (3) @(negedge ref_clk);
    pinIn[idx] = 1'b1;
    repeat (3) @(negedge ref_clk);
    pinIn[idx] = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask : pulseLine
  // Level change on one line
  task automatic setLine(input int idx, input logic val);
    @(negedge ref_clk);
    pinIn[idx] = val;
  endtask : setLine
endmodule : mtio_plc_model
